/* File: src/fnc_pkg.sv */
// Package for the fieldbus node configuration and status block.
// Assumes a 100 MHz clock and a classic Wishbone register bus.
package fnc_pkg;
	// Clock and timing
	localparam int CLK_MHZ = 100;
	localparam int SELFTEST_MS = 250;
	localparam int SELFTEST_CYC = SELFTEST_MS * 1000 * CLK_MHZ;
	localparam int FLASH_MS = 500;
	localparam int FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;

	// Register byte offsets
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ = 8'h0c;
	localparam logic [7:0] OFS_MASK = 8'h10;

	// Rate codes and switch positions
	localparam logic [1:0] RATE_NET = 2'h0;
	localparam logic [1:0] RATE_125 = 2'h1;
	localparam logic [1:0] RATE_250 = 2'h2;
	localparam logic [1:0] RATE_500 = 2'h3;
	localparam logic [1:0] RATE_RST = RATE_500;
	localparam logic [5:0] ADDR_MAX = 6'h3f;
	localparam logic [5:0] ADDR_RST = 6'h3f;

	// Control register fields
	localparam int CTRL_CHK_DONE = 0;
	localparam int CTRL_ONLINE = 1;
	localparam int CTRL_CONN = 2;
	localparam int CTRL_DUP = 3;
	localparam int CTRL_BUSOFF = 4;
	localparam int CTRL_NVLOAD = 5;

	// Interrupt events
	localparam int EV_CFG_LOADED = 0;
	localparam int EV_NET_FAULT = 1;
	localparam int EV_TEST_DONE = 2;
	localparam int EV_W = 3;

	// Indicator colour
	typedef enum logic [1:0] {FNC_OFF, FNC_GREEN, FNC_RED} fnc_led_e;

	// Node configuration carried together
	typedef struct packed {
		logic [1:0] rate;
		logic [5:0] addr;
	} fnc_cfg_s;
endpackage

/* File: src/fnc_led_ind.sv */
// Network status indicator sequencer: power-up test, then status display.
// Assumes status inputs on the same clock as the indicator.
`timescale 1ns/1ps
`default_nettype none
module fnc_led_ind #(
	parameter int TEST_CYC = fnc_pkg::SELFTEST_CYC,
	parameter int BLINK_CYC = fnc_pkg::FLASH_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Status
	input wire logic chk_done_i,
	input wire logic online_i,
	input wire logic conn_i,
	input wire logic fault_i,
	// Indicator
	output logic grn_o,
	output logic red_o,
	output logic test_done_o
);
	typedef enum logic [1:0] {S_GRN, S_RED, S_RUN} fnc_seq_e;
	fnc_seq_e st_r, st_nxt;
	logic [31:0] cnt_r, cnt_nxt;
	logic [31:0] bl_r, bl_nxt;
	logic ph_r, ph_nxt;
	logic grn_r, grn_nxt, red_r, red_nxt, td_r, td_nxt;

	// Sequencer and colour choice
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r + 32'h1;
		bl_nxt = bl_r + 32'h1;
		ph_nxt = ph_r;
		td_nxt = 1'b0;
		grn_nxt = 1'b0;
		red_nxt = 1'b0;
		if (bl_r >= 32'(BLINK_CYC - 1)) begin
			bl_nxt = 32'h0;
			ph_nxt = ~ph_r;
		end
		case (st_r)
			S_GRN: begin
				grn_nxt = 1'b1;
				if (cnt_r >= 32'(TEST_CYC - 1)) begin
					st_nxt = S_RED;
					cnt_nxt = 32'h0;
					grn_nxt = 1'b0;
					red_nxt = 1'b1;
				end
			end
			S_RED: begin
				red_nxt = 1'b1;
				if (cnt_r >= 32'(TEST_CYC - 1)) begin
					st_nxt = S_RUN;
					red_nxt = 1'b0;
					td_nxt = 1'b1;
				end
			end
			S_RUN: begin
				cnt_nxt = cnt_r;
				if (fault_i)
					red_nxt = 1'b1;
				else if (!chk_done_i || !online_i)
					grn_nxt = 1'b0;
				else if (conn_i)
					grn_nxt = 1'b1;
				else
					grn_nxt = ph_r;
			end
			default: st_nxt = S_GRN;
		endcase
	end

	// State registers
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			st_r <= S_GRN;
			cnt_r <= 32'h0;
			bl_r <= 32'h0;
			ph_r <= 1'b0;
			grn_r <= 1'b0;
			red_r <= 1'b0;
			td_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			bl_r <= bl_nxt;
			ph_r <= ph_nxt;
			grn_r <= grn_nxt;
			red_r <= red_nxt;
			td_r <= td_nxt;
		end
	end

	assign grn_o = grn_r;
	assign red_o = red_r;
	assign test_done_o = td_r;

	a_never_both: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!(grn_r && red_r)) else $error("Indicator green and red together");
	a_fault_red: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(st_r == S_RUN && fault_i) |=> red_r)
		else $error("Fault did not show red");
	a_dark_unchk: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(st_r == S_RUN && !fault_i && !chk_done_i) |=> (!grn_r && !red_r))
		else $error("Indicator lit before address check");
	a_solid_green: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(st_r == S_RUN && !fault_i && chk_done_i && online_i && conn_i)
		|=> (grn_r && !red_r))
		else $error("Connected node not solid green");
	a_flash_green: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(st_r == S_RUN && !fault_i && chk_done_i && online_i && !conn_i)
		|=> (grn_r == $past(ph_r)))
		else $error("Unconnected node not flashing");
	// First cycle after reset still shows the dark reset value
	a_test_green: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(st_r == S_GRN && cnt_r != 32'h0) |-> grn_r)
		else $error("Power-up test not green");
	a_test_red: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(st_r == S_RED) |-> (red_r && !grn_r))
		else $error("Power-up test not red");
endmodule
`default_nettype wire

/* File: src/fnc_top.sv */
// Fieldbus node configuration loader with network status indicator.
// Assumes rotary switches on asynchronous pins and a Wishbone master.
`timescale 1ns/1ps
`default_nettype none
module fnc_top #(
	parameter int TEST_CYC = fnc_pkg::SELFTEST_CYC,
	parameter int BLINK_CYC = fnc_pkg::FLASH_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Rotary switches
	input wire logic [1:0] rate_switch_i,
	input wire logic [3:0] tens_digit_switch_i,
	input wire logic [3:0] units_digit_switch_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Node outputs
	output fnc_pkg::fnc_cfg_s cfg_o,
	output logic network_status_led_grn_o,
	output logic network_status_led_red_o,
	output logic irq_o
);
	// Synchronisers for the switch pins
	logic [9:0] sw_s1_r, sw_s2_r;
	// Power-up capture
	logic [1:0] cap_cnt_r, cap_cnt_nxt;
	logic rate_net_r, rate_net_nxt, addr_net_r, addr_net_nxt;
	fnc_pkg::fnc_cfg_s cfg_r, cfg_nxt;
	fnc_pkg::fnc_cfg_s nv_r, nv_nxt;
	// Registers
	logic [5:0] ctrl_r, ctrl_nxt;
	logic [fnc_pkg::EV_W-1:0] irq_st_r, irq_st_nxt, mask_r, mask_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic ack_r, ack_nxt, irq_r, irq_nxt;
	logic fault_d_r, fault_d_nxt;
	logic grn_w, red_w, td_w;
	logic acc, wr, rd;
	logic [fnc_pkg::EV_W-1:0] ev;
	logic [5:0] sw_addr;
	logic [6:0] sw_sum;

	// Address from two decimal digits
	function automatic logic [6:0] dec_addr(input logic [3:0] t,
		input logic [3:0] u);
		// Digits past nine are treated as out of range, not wrapped
		if (t > 4'h9 || u > 4'h9)
			dec_addr = 7'h7f;
		else
			dec_addr = 7'(t) * 7'h0a + 7'(u);
	endfunction

	// Pin synchroniser, two flops
	always_ff @(posedge clk_i) begin
		sw_s1_r <= {rate_switch_i, tens_digit_switch_i, units_digit_switch_i};
		sw_s2_r <= sw_s1_r;
	end

	assign sw_sum = dec_addr(sw_s2_r[7:4], sw_s2_r[3:0]);
	assign sw_addr = sw_sum[5:0];
	assign acc = wb_cyc_i && wb_stb_i && !ack_r;
	assign wr = acc && wb_we_i && wb_sel_i[0];
	assign rd = acc && !wb_we_i;

	// Capture, network writes, bus and interrupts
	always_comb begin
		cap_cnt_nxt = cap_cnt_r;
		rate_net_nxt = rate_net_r;
		addr_net_nxt = addr_net_r;
		cfg_nxt = cfg_r;
		nv_nxt = nv_r;
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		ack_nxt = acc;
		dat_nxt = 32'h0;
		ev = '0;
		if (cap_cnt_r != 2'h3) begin
			// Wait for the synchroniser to fill, then sample once
			cap_cnt_nxt = cap_cnt_r + 2'h1;
			if (cap_cnt_r == 2'h2) begin
				ev[fnc_pkg::EV_CFG_LOADED] = 1'b1;
				if (sw_s2_r[9:8] == fnc_pkg::RATE_NET) begin
					rate_net_nxt = 1'b1;
					cfg_nxt.rate = nv_r.rate;
				end else begin
					rate_net_nxt = 1'b0;
					cfg_nxt.rate = sw_s2_r[9:8];
				end
				if (sw_sum > 7'(fnc_pkg::ADDR_MAX)) begin
					addr_net_nxt = 1'b1;
					cfg_nxt.addr = nv_r.addr;
				end else begin
					addr_net_nxt = 1'b0;
					cfg_nxt.addr = sw_addr;
				end
			end
		end
		if (wr) begin
			case (wb_adr_i)
				fnc_pkg::OFS_CFG: begin
					// Network writes stored value; live only if net-owned
					nv_nxt = wb_dat_i[7:0];
					if (rate_net_r)
						cfg_nxt.rate = wb_dat_i[7:6];
					if (addr_net_r)
						cfg_nxt.addr = wb_dat_i[5:0];
				end
				fnc_pkg::OFS_CTRL: ctrl_nxt = wb_dat_i[5:0];
				fnc_pkg::OFS_MASK: mask_nxt = wb_dat_i[fnc_pkg::EV_W-1:0];
				default: ;
			endcase
		end
		if (rd) begin
			case (wb_adr_i)
				fnc_pkg::OFS_CFG: dat_nxt = {24'h0, cfg_r};
				fnc_pkg::OFS_CTRL: dat_nxt = {26'h0, ctrl_r};
				fnc_pkg::OFS_STAT: dat_nxt = {24'h0, nv_r.rate, rate_net_r,
					addr_net_r, 1'b0, td_w, red_w, grn_w};
				fnc_pkg::OFS_IRQ: dat_nxt = {29'h0, irq_st_r};
				fnc_pkg::OFS_MASK: dat_nxt = {29'h0, mask_r};
				default: dat_nxt = 32'h0;
			endcase
		end
		ev[fnc_pkg::EV_TEST_DONE] = td_w;
		// Fault level, delayed once so its rising edge is an event
		fault_d_nxt = ctrl_r[fnc_pkg::CTRL_DUP] ||
			ctrl_r[fnc_pkg::CTRL_BUSOFF];
		ev[fnc_pkg::EV_NET_FAULT] = fault_d_nxt && !fault_d_r;
		// Read clears; a new event in the same cycle wins
		irq_st_nxt = irq_st_r;
		if (rd && wb_adr_i == fnc_pkg::OFS_IRQ)
			irq_st_nxt = '0;
		irq_st_nxt = irq_st_nxt | ev;
		irq_nxt = |(irq_st_nxt & mask_nxt);
	end

	// Registers
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			cap_cnt_r <= 2'h0;
			rate_net_r <= 1'b0;
			addr_net_r <= 1'b0;
			cfg_r <= '{rate: fnc_pkg::RATE_RST, addr: fnc_pkg::ADDR_RST};
			nv_r <= '{rate: fnc_pkg::RATE_RST, addr: fnc_pkg::ADDR_RST};
			ctrl_r <= 6'h0;
			irq_st_r <= '0;
			mask_r <= '0;
			dat_r <= 32'h0;
			ack_r <= 1'b0;
			irq_r <= 1'b0;
			fault_d_r <= 1'b0;
		end else begin
			cap_cnt_r <= cap_cnt_nxt;
			rate_net_r <= rate_net_nxt;
			addr_net_r <= addr_net_nxt;
			cfg_r <= cfg_nxt;
			nv_r <= nv_nxt;
			ctrl_r <= ctrl_nxt;
			irq_st_r <= irq_st_nxt;
			mask_r <= mask_nxt;
			dat_r <= dat_nxt;
			ack_r <= ack_nxt;
			irq_r <= irq_nxt;
			fault_d_r <= fault_d_nxt;
		end
	end

	// Indicator sequencer
	fnc_led_ind #(
		.TEST_CYC(TEST_CYC),
		.BLINK_CYC(BLINK_CYC)
	) u_led (
		.clk_i(clk_i),
		.nrst_i(nrst_i),
		.chk_done_i(ctrl_r[fnc_pkg::CTRL_CHK_DONE]),
		.online_i(ctrl_r[fnc_pkg::CTRL_ONLINE]),
		.conn_i(ctrl_r[fnc_pkg::CTRL_CONN]),
		.fault_i(ctrl_r[fnc_pkg::CTRL_DUP] || ctrl_r[fnc_pkg::CTRL_BUSOFF]),
		.grn_o(grn_w),
		.red_o(red_w),
		.test_done_o(td_w)
	);

	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;
	assign cfg_o = cfg_r;
	assign network_status_led_grn_o = grn_w;
	assign network_status_led_red_o = red_w;
	assign irq_o = irq_r;

	// Settled configuration moves only by a network write
	a_switch_hold: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(cap_cnt_r == 2'h3 && !wr) |=> $stable(cfg_r))
		else $error("Configuration moved without a network write");

	// Address above the switch range comes from memory
	a_addr_net: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(cap_cnt_r == 2'h2 && sw_sum > 7'h3f) |=> (addr_net_r &&
		cfg_r.addr == $past(nv_r.addr)))
		else $error("High address not taken from memory");

	// Address in range comes straight from the digits
	a_addr_sw: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(cap_cnt_r == 2'h2 && sw_sum <= 7'h3f) |=> (!addr_net_r &&
		cfg_r.addr == $past(sw_addr)))
		else $error("Switch address not taken");

	// Network rate position loads the stored rate
	a_rate_net: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(cap_cnt_r == 2'h2 && sw_s2_r[9:8] == 2'h0) |=> (rate_net_r &&
		cfg_r.rate == $past(nv_r.rate)))
		else $error("Network rate not loaded");

	// Other rate positions are taken as they stand
	a_rate_sw: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(cap_cnt_r == 2'h2 && sw_s2_r[9:8] != 2'h0) |=> (!rate_net_r &&
		cfg_r.rate == $past(sw_s2_r[9:8])))
		else $error("Switch rate not taken");

	// Switches are sampled once and then left alone
	a_capture_once: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(cap_cnt_r == 2'h3) |=> (cap_cnt_r == 2'h3))
		else $error("Switches sampled again");

	// A network write always lands in the stored copy
	a_store_write: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(wr && wb_adr_i == fnc_pkg::OFS_CFG) |=>
		(nv_r == $past(wb_dat_i[7:0])))
		else $error("Stored configuration not written");

	// A switch-owned address ignores network writes
	a_addr_owned: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(cap_cnt_r == 2'h3 && wr && wb_adr_i == fnc_pkg::OFS_CFG &&
		!addr_net_r) |=> $stable(cfg_r.addr))
		else $error("Switch address changed by a write");

	// A network-owned address follows the write
	a_addr_write: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(cap_cnt_r == 2'h3 && wr && wb_adr_i == fnc_pkg::OFS_CFG &&
		addr_net_r) |=> (cfg_r.addr == $past(wb_dat_i[5:0])))
		else $error("Network address write not applied");

	// A switch-owned rate ignores network writes
	a_rate_owned: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(cap_cnt_r == 2'h3 && wr && wb_adr_i == fnc_pkg::OFS_CFG &&
		!rate_net_r) |=> $stable(cfg_r.rate))
		else $error("Switch rate changed by a write");

	// A fault edge raises its sticky status bit
	a_fault_event: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(fault_d_nxt && !fault_d_r) |=> irq_st_r[fnc_pkg::EV_NET_FAULT])
		else $error("Fault event lost");

	// Status bits stay set until the interrupt status register is read
	a_irq_sticky: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		!(rd && wb_adr_i == fnc_pkg::OFS_IRQ) |=>
		((irq_st_r & $past(irq_st_r)) == $past(irq_st_r)))
		else $error("Status bit lost without a read");

	// A clearing read keeps only events of the same cycle
	a_irq_clear: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(rd && wb_adr_i == fnc_pkg::OFS_IRQ) |=> (irq_st_r == $past(ev)))
		else $error("Status read did not clear");

	// Interrupt line follows the masked status
	a_irq_level: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		irq_r == |(irq_st_r & mask_r))
		else $error("Interrupt line wrong");

	// Each request gets one answer cycle, then a gap
	a_bus_ack: assert property (@(posedge clk_i)
		disable iff (!nrst_i)
		(wb_cyc_i && wb_stb_i && !ack_r) |=> ack_r ##1 !ack_r)
		else $error("Bus answer not one cycle");
endmodule
`default_nettype wire

/* File: bench/fnc_switch_panel.sv */
// Rotary switch panel model: rate and two address digits, set by the operator.
// Assumes the bench picks one of a few preset panel settings.
`timescale 1ns/1ps
`default_nettype none
module fnc_switch_panel (
	// Preset choice
	input wire logic [1:0] setting_i,
	// Switch levels
	output logic [1:0] rate_o,
	output logic [3:0] tens_o,
	output logic [3:0] units_o
);
	// Presets: direct 250k/42, direct 125k/63, network, 250k with 64
	always_comb begin
		case (setting_i)
			2'h0: {rate_o, tens_o, units_o} = {2'h2, 4'h4, 4'h2};
			2'h1: {rate_o, tens_o, units_o} = {2'h1, 4'h6, 4'h3};
			2'h2: {rate_o, tens_o, units_o} = {2'h0, 4'h7, 4'h0};
			default: {rate_o, tens_o, units_o} = {2'h2, 4'h6, 4'h4};
		endcase
	end
endmodule
`default_nettype wire

/* File: bench/test_fieldbus_node_config_status.sv */
// Self-checking bench for the node configuration and status block.
// Assumes the shortened test and flash counts set below.
`timescale 1ns/1ps
`default_nettype none
module test_fieldbus_node_config_status;
	logic clk_i, nrst_i, cyc, stb, we;
	logic [1:0] setting, rsw;
	logic [3:0] tsw, usw, sel;
	logic [7:0] adr;
	logic [31:0] wdat, rd, rdat;
	logic ack, grn, red, irq;
	fnc_pkg::fnc_cfg_s cfg;
	int err_count = 0;
	int samples_checked = 0;
	int h;
	logic [7:0] exp_cfg [1:3] = '{8'h7f, 8'hff, 8'hbf};

	fnc_switch_panel panel (.setting_i(setting), .rate_o(rsw), .tens_o(tsw),
		.units_o(usw));
	fnc_top #(.TEST_CYC(20), .BLINK_CYC(8)) uut (.clk_i(clk_i), .nrst_i(nrst_i),
		.rate_switch_i(rsw), .tens_digit_switch_i(tsw),
		.units_digit_switch_i(usw), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .cfg_o(cfg),
		.network_status_led_grn_o(grn), .network_status_led_red_o(red),
		.irq_o(irq));

	// Clock
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
			err_count++;
		end
	endtask

	// One classic cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		rd = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		if (n >= 50) err_count++;
	endtask

	task automatic boot(input logic [1:0] s);
		@(posedge clk_i);
		nrst_i <= 1'b0;
		setting <= s;
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'b1;
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic end_sim;
		$display("checks=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		end_sim();
	end

	// Main sequence
	initial begin
		{nrst_i, cyc, stb, we, adr, wdat, setting} = '0;
		sel = 4'hf;
		boot(2'h0);
		wait_n(6);
		chk(32'(cfg), 32'haa);
		chk({grn, red}, 2'b10);
		wait_n(24);
		chk({grn, red}, 2'b01);
		wait_n(22);
		chk({grn, red}, 2'b00);
		wb(1'b0, fnc_pkg::OFS_STAT, 0);
		chk(rd, 32'hc0);
		setting <= 2'h2;
		wb(1'b1, fnc_pkg::OFS_CFG, 32'h45);
		wait_n(4);
		chk(32'(cfg), 32'haa);
		wb(1'b0, 8'h20, 0);
		chk(rd, 32'h0);
		$display("test power-up done");
		wb(1'b1, fnc_pkg::OFS_MASK, 32'h4);
		wait_n(2);
		chk(irq, 1'b1);
		wb(1'b0, fnc_pkg::OFS_IRQ, 0);
		chk(rd, 32'h5);
		wait_n(2);
		chk(irq, 1'b0);
		wb(1'b1, fnc_pkg::OFS_MASK, 32'h2);
		$display("test interrupt done");
		wb(1'b1, fnc_pkg::OFS_CTRL, 32'h03);
		wait_n(3);
		h = 0;
		for (int i = 0; i < 24; i++) begin
			@(negedge clk_i);
			h += int'(grn === 1'b1);
		end
		chk(h > 0 && h < 24, 1'b1);
		wb(1'b1, fnc_pkg::OFS_CTRL, 32'h07);
		wait_n(12);
		chk({grn, red}, 2'b10);
		wb(1'b1, fnc_pkg::OFS_CTRL, 32'h0f);
		wait_n(3);
		chk({grn, red, irq}, 3'b011);
		wb(1'b1, fnc_pkg::OFS_CTRL, 32'h13);
		wait_n(3);
		chk({grn, red}, 2'b01);
		$display("test status done");
		for (int s = 1; s < 4; s++) begin
			boot(2'(s));
			wait_n(6);
			chk(32'(cfg), 32'(exp_cfg[s]));
		end
		wb(1'b1, fnc_pkg::OFS_CFG, 32'h45);
		wait_n(3);
		chk(32'(cfg), 32'h85);
		wb(1'b0, fnc_pkg::OFS_CFG, 0);
		chk(rd, 32'h85);
		$display("test switches done");
		end_sim();
	end
endmodule
`default_nettype wire
